// File: core/jack_consts.svh
// timing, width and reset constants for the accessory detector
`ifndef JACK_CONSTS_SVH
`define JACK_CONSTS_SVH

`define JACK_CLK_PERIOD_NS  40
`define JACK_DEB_BASE_NS    100000
`define JACK_DEB_BASE_CYC   ((`JACK_DEB_BASE_NS + `JACK_CLK_PERIOD_NS - 1) / `JACK_CLK_PERIOD_NS)
`define JACK_CNT_W          16
`define JACK_DEB_SEL_W      2
`define JACK_KEY_COUNT      4
`define JACK_CNT_ZERO       16'h0000
`define JACK_CNT_ONE        16'h0001
`define JACK_KEYS_ZERO      4'h0

`endif

// File: core/jack_pkg.sv
// types shared by the accessory detector
`include "jack_consts.svh"

package jack_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP    = 3'h0,
        ST_DEB_IN   = 3'h1,
        ST_CLASSIFY = 3'h3,
        ST_ACTIVE   = 3'h2,
        ST_DEB_OUT  = 3'h6
    } det_state_t;

    typedef enum logic [1:0] {
        PLUG_NONE         = 2'h0,
        PLUG_THREE_POLE   = 2'h1,
        PLUG_MIC_SLEEVE   = 2'h2,
        PLUG_MIC_RING_TWO = 2'h3
    } plug_t;

    // one bit per analog switch, high closes it
    typedef struct packed {
        logic ring_two_sense_to_mic;
        logic ring_two_sense_to_gsense;
        logic sleeve_sense_to_mic;
        logic sleeve_sense_to_gsense;
        logic ring_two_return_gnd;
        logic sleeve_return_gnd;
        logic mic_bias_supply_on;
    } switch_t;

    typedef struct packed {
        det_state_t                    st;
        plug_t                         plug;
        logic [`JACK_CNT_W-1:0]        cnt;
        logic                          det_prev;
        switch_t                       sw;
        logic                          mic_flag;
        logic                          irq;
        logic                          sleep;
        logic [`JACK_KEY_COUNT-1:0]    keys;
        logic [`JACK_KEY_COUNT-1:0]    key_press;
        logic [`JACK_KEY_COUNT-1:0]    key_release;
    } core_state_t;

endpackage

// File: core/audio_jack_accessory_detect.sv
// accessory detection, plug classification, switch routing, keys and host notify
`timescale 1ns/1ns
`include "jack_consts.svh"

module audio_jack_accessory_detect #(
    parameter int DEB_BASE_CYC = `JACK_DEB_BASE_CYC
) (
    input  wire logic                           mclk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           accessory_detect_edge_i,
    input  wire logic                           ring_two_mic_i,
    input  wire logic                           sleeve_mic_i,
    input  wire logic [`JACK_KEY_COUNT-1:0]     key_level_i,
    input  wire logic [`JACK_DEB_SEL_W-1:0]     debounce_sel_i,
    input  wire logic                           manual_mode_i,
    input  wire jack_pkg::switch_t              manual_sw_i,
    input  wire logic                           int_ack_i,
    output jack_pkg::switch_t                   switch_o,
    output jack_pkg::plug_t                     plug_type_o,
    output logic [`JACK_KEY_COUNT-1:0]          key_state_o,
    output logic [`JACK_KEY_COUNT-1:0]          key_press_o,
    output logic [`JACK_KEY_COUNT-1:0]          key_release_o,
    output logic                                sleep_o,
    output logic                                irq_oe_o,
    output logic                                mic_headset_flag_oe_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic jack_pkg::switch_t route_for(input jack_pkg::plug_t p);
        jack_pkg::switch_t s;
        s = '0;
        case (p)
            jack_pkg::PLUG_MIC_RING_TWO: begin
                s.ring_two_sense_to_mic  = 1'b1;
                s.sleeve_sense_to_gsense = 1'b1;
                s.sleeve_return_gnd      = 1'b1;
                s.mic_bias_supply_on     = 1'b1;
            end
            jack_pkg::PLUG_MIC_SLEEVE: begin
                s.sleeve_sense_to_mic      = 1'b1;
                s.ring_two_sense_to_gsense = 1'b1;
                s.ring_two_return_gnd      = 1'b1;
                s.mic_bias_supply_on       = 1'b1;
            end
            jack_pkg::PLUG_THREE_POLE: begin
                s.ring_two_sense_to_gsense = 1'b1;
                s.sleeve_sense_to_gsense   = 1'b1;
                s.ring_two_return_gnd      = 1'b1;
                s.sleeve_return_gnd        = 1'b1;
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction

    function automatic logic has_mic(input jack_pkg::plug_t p);
        return (p == jack_pkg::PLUG_MIC_RING_TWO) || (p == jack_pkg::PLUG_MIC_SLEEVE);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    jack_pkg::core_state_t       cur;
    jack_pkg::core_state_t       next_cur;
    logic [`JACK_CNT_W-1:0]      deb_last;
    logic                        deb_done;
    logic                        fall_seen;
    jack_pkg::switch_t           auto_sw;
    logic                        detect_evt;
    logic [`JACK_KEY_COUNT-1:0]  press_now;
    logic [`JACK_KEY_COUNT-1:0]  release_now;

    // debounce length is base times selection plus one
    assign deb_last  = `JACK_CNT_W'(DEB_BASE_CYC * (int'(debounce_sel_i) + 1) - 1);
    // >= so a host shortening the interval mid-count cannot make the counter wrap
    assign deb_done  = (cur.cnt >= deb_last);
    assign fall_seen = cur.det_prev && !accessory_detect_edge_i;

    always_comb begin
        next_cur          = cur;
        next_cur.det_prev = accessory_detect_edge_i;
        next_cur.cnt      = `JACK_CNT_ZERO;
        auto_sw           = '0;
        detect_evt        = 1'b0;
        press_now         = `JACK_KEYS_ZERO;
        release_now       = `JACK_KEYS_ZERO;

        case (cur.st)
            jack_pkg::ST_SLEEP: begin
                // start detection on the falling edge
                if (fall_seen) begin
                    next_cur.st = jack_pkg::ST_DEB_IN;
                end
            end
            jack_pkg::ST_DEB_IN: begin
                // pin must stay low for the whole interval
                if (accessory_detect_edge_i) begin
                    next_cur.st = jack_pkg::ST_SLEEP;
                end else if (deb_done) begin
                    next_cur.st = jack_pkg::ST_CLASSIFY;
                end else begin
                    next_cur.cnt = cur.cnt + `JACK_CNT_ONE;
                end
            end
            jack_pkg::ST_CLASSIFY: begin
                // ring-two mic wins if both comparators fire
                if (ring_two_mic_i) begin
                    next_cur.plug = jack_pkg::PLUG_MIC_RING_TWO;
                end else if (sleeve_mic_i) begin
                    next_cur.plug = jack_pkg::PLUG_MIC_SLEEVE;
                end else begin
                    next_cur.plug = jack_pkg::PLUG_THREE_POLE;
                end
                next_cur.st = jack_pkg::ST_ACTIVE;
                detect_evt  = 1'b1;
            end
            jack_pkg::ST_ACTIVE: begin
                if (accessory_detect_edge_i) begin
                    next_cur.st = jack_pkg::ST_DEB_OUT;
                end else if (has_mic(cur.plug)) begin
                    // edges of each key level give press and release
                    for (int k = 0; k < `JACK_KEY_COUNT; k++) begin
                        press_now[k]   = key_level_i[k] && !cur.keys[k];
                        release_now[k] = !key_level_i[k] && cur.keys[k];
                    end
                    next_cur.keys = key_level_i;
                end
            end
            jack_pkg::ST_DEB_OUT: begin
                // removal debounce; a bounce back low resumes
                if (!accessory_detect_edge_i) begin
                    next_cur.st = jack_pkg::ST_ACTIVE;
                end else if (deb_done) begin
                    next_cur.st   = jack_pkg::ST_SLEEP;
                    next_cur.plug = jack_pkg::PLUG_NONE;
                    next_cur.keys = `JACK_KEYS_ZERO;
                    detect_evt    = 1'b1;
                end else begin
                    next_cur.cnt = cur.cnt + `JACK_CNT_ONE;
                end
            end
            default: begin
                next_cur.st = jack_pkg::ST_SLEEP;
            end
        endcase

        // automatic routing follows the classified plug only while settled
        // bias stays isolated outside the settled state unless manual_mode_i applies manual_sw_i
        if (next_cur.st == jack_pkg::ST_ACTIVE) begin
            auto_sw = route_for(next_cur.plug);
        end
        next_cur.sw = manual_mode_i ? manual_sw_i : auto_sw;

        // cleared together with the plug on removal
        next_cur.mic_flag = has_mic(next_cur.plug);

        // sleep flag registered with the state
        next_cur.sleep = (next_cur.st == jack_pkg::ST_SLEEP);

        // sticky event bits; a new event beats the host clear
        next_cur.key_press   = (int_ack_i ? `JACK_KEYS_ZERO : cur.key_press) | press_now;
        next_cur.key_release = (int_ack_i ? `JACK_KEYS_ZERO : cur.key_release) | release_now;

        // any detection or key event raises the interrupt
        // held until the host acknowledges, set wins
        next_cur.irq = (cur.irq && !int_ack_i) || detect_evt || (|press_now) || (|release_now);
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cur          <= '0;
            cur.st       <= jack_pkg::ST_SLEEP;
            cur.plug     <= jack_pkg::PLUG_NONE;
            cur.det_prev <= 1'b1;
            cur.sleep    <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open-drain pins: enable high pulls the line low
    assign switch_o              = cur.sw;
    assign plug_type_o           = cur.plug;
    assign key_state_o           = cur.keys;
    assign key_press_o           = cur.key_press;
    assign key_release_o         = cur.key_release;
    // sleep is the idle state with nothing inserted
    assign sleep_o               = cur.sleep;
    assign irq_oe_o              = cur.irq;
    assign mic_headset_flag_oe_o = cur.mic_flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_detect_start: assert property (
        cur.st == jack_pkg::ST_SLEEP && fall_seen |=> cur.st == jack_pkg::ST_DEB_IN)
        else $error("falling detect edge did not start debounce");

    chk_debounce_hold: assert property (
        cur.st == jack_pkg::ST_DEB_IN && !accessory_detect_edge_i && !deb_done
        |=> cur.st == jack_pkg::ST_DEB_IN && cur.cnt == $past(cur.cnt) + `JACK_CNT_ONE)
        else $error("insertion debounce left early or did not count");

    chk_debounce_end: assert property (
        cur.st == jack_pkg::ST_DEB_IN && !accessory_detect_edge_i && deb_done
        |=> cur.st == jack_pkg::ST_CLASSIFY ##1 cur.st == jack_pkg::ST_ACTIVE)
        else $error("insertion debounce did not end in classification");

    chk_classify_ring: assert property (
        cur.st == jack_pkg::ST_CLASSIFY && ring_two_mic_i
        |=> cur.plug == jack_pkg::PLUG_MIC_RING_TWO)
        else $error("ring-two microphone not classified");

    chk_classify_sleeve: assert property (
        cur.st == jack_pkg::ST_CLASSIFY && !ring_two_mic_i && sleeve_mic_i
        |=> cur.plug == jack_pkg::PLUG_MIC_SLEEVE)
        else $error("sleeve microphone not classified");

    chk_classify_three: assert property (
        cur.st == jack_pkg::ST_CLASSIFY && !ring_two_mic_i && !sleeve_mic_i
        |=> cur.plug == jack_pkg::PLUG_THREE_POLE)
        else $error("three-pole plug not classified");

    chk_ring_route: assert property (
        cur.st == jack_pkg::ST_ACTIVE && cur.plug == jack_pkg::PLUG_MIC_RING_TWO
        && !accessory_detect_edge_i && !manual_mode_i
        |=> cur.sw.ring_two_sense_to_mic && !cur.sw.ring_two_sense_to_gsense)
        else $error("ring-two sense not routed to mic line");

    chk_sleeve_route: assert property (
        cur.st == jack_pkg::ST_ACTIVE && cur.plug != jack_pkg::PLUG_MIC_SLEEVE
        && !accessory_detect_edge_i && !manual_mode_i
        |=> !cur.sw.sleeve_sense_to_mic && cur.sw.sleeve_sense_to_gsense)
        else $error("sleeve sense not routed to ground sense");

    chk_bias_isolated: assert property (
        (cur.st == jack_pkg::ST_DEB_IN || cur.st == jack_pkg::ST_DEB_OUT && accessory_detect_edge_i)
        && !manual_mode_i |=> !cur.sw.mic_bias_supply_on)
        else $error("mic bias connected during plug movement");

    chk_mic_flag: assert property (
        cur.st == jack_pkg::ST_CLASSIFY |=> cur.mic_flag == ($past(ring_two_mic_i) || $past(sleeve_mic_i)))
        else $error("mic_headset_flag active without a mic plug");

    chk_irq_hold: assert property (
        cur.irq && !int_ack_i |=> cur.irq)
        else $error("interrupt released before service");

    chk_irq_clear: assert property (
        cur.irq && int_ack_i && !detect_evt && press_now == `JACK_KEYS_ZERO && release_now == `JACK_KEYS_ZERO
        |=> !cur.irq)
        else $error("interrupt not released after service");

    chk_sleep_state: assert property (
        sleep_o |-> cur.plug == jack_pkg::PLUG_NONE && !cur.mic_flag)
        else $error("sleep while an accessory is classified");

    chk_removal_clear: assert property (
        cur.st == jack_pkg::ST_DEB_OUT && accessory_detect_edge_i && deb_done
        |=> sleep_o && !cur.mic_flag && cur.irq ##1 !cur.mic_flag)
        else $error("removal did not clear mic flag or notify");

    chk_manual_sw: assert property (
        manual_mode_i |=> cur.sw == $past(manual_sw_i))
        else $error("host switch override not applied");

    for (genvar g = 0; g < `JACK_KEY_COUNT; g++) begin : g_key_chk
        chk_key_press: assert property (
            cur.st == jack_pkg::ST_ACTIVE && has_mic(cur.plug) && !accessory_detect_edge_i
            && key_level_i[g] && !cur.keys[g] |=> cur.key_press[g] && cur.irq)
            else $error("key press not reported");
        chk_key_release: assert property (
            cur.st == jack_pkg::ST_ACTIVE && has_mic(cur.plug) && !accessory_detect_edge_i
            && !key_level_i[g] && cur.keys[g] |=> cur.key_release[g] && cur.irq)
            else $error("key release not reported");
    end

endmodule

// File: sim/jack_plug_model.sv
// far-side model: jack contacts, plug comparators, keys and open-drain pull-ups
`timescale 1ns/1ns
`include "jack_consts.svh"

module jack_plug_model (
    input  wire logic                         mclk_i,
    input  wire jack_pkg::plug_t              plug_cmd_i,
    input  wire logic [`JACK_KEY_COUNT-1:0]   key_cmd_i,
    input  wire logic                         irq_oe_i,
    input  wire logic                         mic_oe_i,
    output logic                              detect_pin_o,
    output logic                              ring_two_mic_o,
    output logic                              sleeve_mic_o,
    output logic [`JACK_KEY_COUNT-1:0]        key_level_o,
    output logic                              irq_line_n_o,
    output logic                              mic_line_n_o
);
    logic plugged;
    logic churn = 1'b0;

    // an open contact floats, so the comparators must not hold a stale value
    always @(posedge mclk_i) churn <= ~churn;
    assign plugged = (plug_cmd_i != jack_pkg::PLUG_NONE);
    assign detect_pin_o = ~plugged;
    assign ring_two_mic_o = plugged ? (plug_cmd_i == jack_pkg::PLUG_MIC_RING_TWO) : churn;
    assign sleeve_mic_o = plugged ? (plug_cmd_i == jack_pkg::PLUG_MIC_SLEEVE) : ~churn;
    assign key_level_o = plugged ? key_cmd_i : `JACK_KEYS_ZERO;
    // host attached, so the interrupt line gets a pull-up, not a ground tie
    assign irq_line_n_o = irq_oe_i ? 1'b0 : 1'b1;
    assign mic_line_n_o = mic_oe_i ? 1'b0 : 1'b1;
endmodule

// File: sim/audio_jack_accessory_detect_tb_top.sv
// self-checking bench for the accessory detector with a scoreboard queue
`timescale 1ns/1ns
`include "jack_consts.svh"

module audio_jack_accessory_detect_tb_top;
    localparam int BASE = 4;
    logic mclk_i, sys_rst_i, det, r2_mic, slv_mic, manual_mode, int_ack, irq_oe, mic_oe, sleep, irq_n, mic_n, irq_prev;
    logic [3:0] key_lvl, key_cmd, key_state, key_press, key_release;
    logic [1:0] deb_sel;
    jack_pkg::switch_t manual_sw, sw;
    jack_pkg::plug_t plug_cmd, plug;
    logic [17:0] notes[$];
    int fail_count, total_checks, dlen;

    audio_jack_accessory_detect #(.DEB_BASE_CYC(BASE)) u_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .accessory_detect_edge_i(det), .ring_two_mic_i(r2_mic),
        .sleeve_mic_i(slv_mic), .key_level_i(key_lvl), .debounce_sel_i(deb_sel), .manual_mode_i(manual_mode),
        .manual_sw_i(manual_sw), .int_ack_i(int_ack), .switch_o(sw), .plug_type_o(plug),
        .key_state_o(key_state), .key_press_o(key_press), .key_release_o(key_release), .sleep_o(sleep),
        .irq_oe_o(irq_oe), .mic_headset_flag_oe_o(mic_oe));

    jack_plug_model u_jack (
        .mclk_i(mclk_i), .plug_cmd_i(plug_cmd), .key_cmd_i(key_cmd), .irq_oe_i(irq_oe), .mic_oe_i(mic_oe),
        .detect_pin_o(det), .ring_two_mic_o(r2_mic), .sleeve_mic_o(slv_mic), .key_level_o(key_lvl),
        .irq_line_n_o(irq_n), .mic_line_n_o(mic_n));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // switch patterns follow the routing per plug type
    function automatic logic [17:0] expect_of(jack_pkg::plug_t p, logic [3:0] pr, logic [3:0] rl);
        jack_pkg::switch_t s;
        case (p)
            jack_pkg::PLUG_MIC_RING_TWO: s = 7'h4b;
            jack_pkg::PLUG_MIC_SLEEVE:   s = 7'h35;
            jack_pkg::PLUG_THREE_POLE:   s = 7'h2e;
            default:                     s = 7'h00;
        endcase
        return {p, s, p[1], pr, rl};
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // every wait is bounded; running out ends the run
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 200; i++) begin
            @(posedge mclk_i);
            if (irq_oe === lvl) return;
        end
        check(18'(irq_oe), 18'(lvl));
        end_of_test();
    endtask

    task automatic ack();
        @(posedge mclk_i);
        int_ack <= 1'b1;
        @(posedge mclk_i);
        int_ack <= 1'b0;
        wait_irq(1'b0);
        check(18'({key_press, key_release, irq_n}), 18'h1);
    endtask

    task automatic insert(input jack_pkg::plug_t p);
        @(posedge mclk_i);
        deb_sel <= 2'($urandom % 4);
        tick(1);
        dlen = BASE * (deb_sel + 1);
        notes.push_back(expect_of(p, 4'h0, 4'h0));
        plug_cmd <= p;
        tick(dlen);
        check(18'(irq_oe), 18'h0);
        wait_irq(1'b1);
        ack();
    endtask

    task automatic remove();
        notes.push_back(expect_of(jack_pkg::PLUG_NONE, 4'h0, 4'h0));
        plug_cmd <= jack_pkg::PLUG_NONE;
        tick(4);
        check(18'(sw), 18'h0);
        wait_irq(1'b1);
        check(18'(sleep), 18'h1);
        ack();
    endtask

    // scoreboard: each rising interrupt consumes the oldest note
    initial begin
        irq_prev = 1'b0;
        forever begin
            @(posedge mclk_i);
            if (sys_rst_i === 1'b0 && irq_oe === 1'b1 && irq_prev !== 1'b1) begin
                if (notes.size() == 0) begin
                    fail_count++;
                    $display("BAD at %0t seen %h expected %h", $time, plug, 2'h0);
                end else begin
                    check({plug, sw, ~mic_n, key_press, key_release}, notes.pop_front());
                end
            end
            irq_prev = irq_oe;
        end
    end

    initial begin
        logic [3:0] k;
        jack_pkg::plug_t p;
        sys_rst_i = 1'b1;
        plug_cmd = jack_pkg::PLUG_NONE;
        key_cmd = 4'h0;
        deb_sel = 2'h0;
        manual_mode = 1'b0;
        manual_sw = 7'h00;
        int_ack = 1'b0;
        void'($urandom(32'haa7daf04));
        tick(5);
        sys_rst_i <= 1'b0;
        tick(2);
        check(18'({sleep, irq_oe, sw}), 18'h100);
        for (int i = 1; i < 4; i++) begin
            p = jack_pkg::plug_t'(2'(i));
            insert(p);
            k = 4'(($urandom % 15) + 1);
            if (p[1]) begin
                notes.push_back(expect_of(p, k, 4'h0));
                key_cmd <= k;
                wait_irq(1'b1);
                check(18'(key_state), 18'(k));
                ack();
                notes.push_back(expect_of(p, 4'h0, k));
                key_cmd <= 4'h0;
                wait_irq(1'b1);
                ack();
            end else begin
                key_cmd <= 4'hf;
                tick(6);
                check(18'({key_press, irq_oe}), 18'h0);
                key_cmd <= 4'h0;
            end
            remove();
            $display("plug type %0d done", i);
        end
        deb_sel <= 2'h3;
        plug_cmd <= jack_pkg::PLUG_MIC_SLEEVE;
        tick(8);
        plug_cmd <= jack_pkg::PLUG_NONE;
        tick(20);
        check(18'({plug, sleep}), 18'h1);
        $display("short pulse test done");
        manual_sw <= 7'($urandom);
        manual_mode <= 1'b1;
        tick(3);
        check(18'(sw), 18'(manual_sw));
        manual_mode <= 1'b0;
        $display("override test done");
        tick(2);
        check(18'(notes.size()), 18'h0);
        end_of_test();
    end
endmodule
